// file: core/clr_crc16.sv
`timescale 1ns/1ps
`default_nettype none
module clr_crc16 #(
    parameter logic [15:0] POLY = clr_pkg::CRC_POLY,
    parameter logic [15:0] INIT = clr_pkg::CRC_INIT
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic restart,
    input wire logic step,
    input wire logic bit_in,
    output logic [15:0] crc_next,
    output logic [15:0] crc_q
);
    import clr_pkg::*;

    // ----------------------------------------------------------------
    // Serial shift, one message bit per step, MSB first
    // ----------------------------------------------------------------
    wire feedback = crc_q[15] ^ bit_in;
    assign crc_next = {crc_q[14:0], 1'b0} ^ (feedback ? POLY : 16'h0000);

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            crc_q <= INIT;
        end else if (restart) begin
            crc_q <= INIT;
        end else if (step) begin
            crc_q <= crc_next;
        end
    end
endmodule : clr_crc16
`default_nettype wire

// file: core/clr_lock_regs.sv
`timescale 1ns/1ps
`default_nettype none
module clr_lock_regs #(
    parameter logic [1:0] DEV_ADDR = clr_pkg::DEV_ADDR_DEFAULT
) (
    input wire logic CLK,
    input wire logic RST_B,
    input wire logic CMD_VALID,
    input wire logic [1:0] CMD_DEV_ADDR,
    input wire logic [3:0] CMD_REG_ADDR,
    input wire logic CMD_WRITE,
    input wire logic [clr_pkg::WORD_W-1:0] CMD_WDATA,
    input wire logic MODULATOR_CLOCK_TICK,
    output logic RD_VALID,
    output logic [clr_pkg::WORD_W-1:0] RD_DATA,
    output logic WRITE_LOCKED,
    output logic [clr_pkg::WORD_W-1:0] TIMER_VALUE,
    output logic [clr_pkg::WORD_W-1:0] OFFSET_TRIM,
    output logic [clr_pkg::WORD_W-1:0] GAIN_TRIM
);
    import clr_pkg::*;

    // ----------------------------------------------------------------
    // Reset release
    // ----------------------------------------------------------------
    logic rst_meta_q;
    logic rst_n_q;
    always_ff @(posedge CLK or negedge RST_B) begin
        if (!RST_B) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // ----------------------------------------------------------------
    // Command decode
    // ----------------------------------------------------------------
    logic [23:0] timer_q;
    logic [23:0] offset_q;
    logic [23:0] gain_q;
    logic [23:0] fixed_b_q;
    logic [7:0] fixed_c_q;
    logic [7:0] lock_q;
    logic [15:0] fixed_e_q;
    logic [15:0] checksum_q;
    logic [6:0] bit_cnt_q;

    wire locked = (lock_q != UNLOCK_KEY);
    // Commands for the lower half of the map belong to another block.
    wire addressed = CMD_VALID && (CMD_DEV_ADDR == DEV_ADDR)
                     && (CMD_REG_ADDR[3] == ADDR_UPPER_BIT);
    wire wr = addressed && CMD_WRITE;
    wire rd = addressed && !CMD_WRITE;
    // A locked map still takes a new key, otherwise it could never be opened.
    wire wr_open = wr && !locked;
    wire we_timer = wr_open && (CMD_REG_ADDR == ADDR_TIMER);
    wire we_offset = wr_open && (CMD_REG_ADDR == ADDR_OFFSET);
    wire we_gain = wr_open && (CMD_REG_ADDR == ADDR_GAIN);
    wire we_fixed_b = wr_open && (CMD_REG_ADDR == ADDR_FIXED_B);
    wire we_fixed_c = wr_open && (CMD_REG_ADDR == ADDR_FIXED_C);
    wire we_fixed_e = wr_open && (CMD_REG_ADDR == ADDR_FIXED_E);
    wire we_lock = wr && (CMD_REG_ADDR == ADDR_LOCK);
    wire [7:0] lock_d = we_lock ? CMD_WDATA[7:0] : lock_q;

    logic [23:0] rd_mux;
    always_comb begin
        case (CMD_REG_ADDR)
            ADDR_TIMER: rd_mux = timer_q;
            ADDR_OFFSET: rd_mux = offset_q;
            ADDR_GAIN: rd_mux = gain_q;
            ADDR_FIXED_B: rd_mux = fixed_b_q;
            ADDR_FIXED_C: rd_mux = {16'h0000, fixed_c_q};
            ADDR_LOCK: rd_mux = {16'h0000, lock_q};
            ADDR_FIXED_E: rd_mux = {8'h00, fixed_e_q};
            ADDR_CHECKSUM: rd_mux = {8'h00, checksum_q};
            default: rd_mux = 24'h000000;
        endcase
    end

    // ----------------------------------------------------------------
    // Configuration registers
    // ----------------------------------------------------------------
    // The fixed registers are plain storage: holding their values is up
    // to the host, and a stray write while unlocked is kept so that the checksum shows it.
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            timer_q <= RST_TIMER;
            offset_q <= RST_OFFSET;
            gain_q <= RST_GAIN;
            fixed_b_q <= RST_FIXED_B;
            fixed_c_q <= RST_FIXED_C;
            lock_q <= RST_LOCK;
            fixed_e_q <= RST_FIXED_E;
        end else begin
            if (we_timer) timer_q <= CMD_WDATA;
            if (we_offset) offset_q <= CMD_WDATA;
            if (we_gain) gain_q <= CMD_WDATA;
            if (we_fixed_b) fixed_b_q <= CMD_WDATA;
            if (we_fixed_c) fixed_c_q <= CMD_WDATA[7:0];
            if (we_fixed_e) fixed_e_q <= CMD_WDATA[15:0];
            lock_q <= lock_d;
        end
    end

    // ----------------------------------------------------------------
    // Configuration checksum
    // ----------------------------------------------------------------
    wire [CRC_STREAM_W-1:0] stream = {timer_q, offset_q, gain_q, fixed_b_q,
                                      fixed_c_q, lock_q, fixed_e_q};
    wire [6:0] bit_sel = CRC_LAST_BIT - bit_cnt_q;
    wire crc_step = locked && MODULATOR_CLOCK_TICK;
    wire pass_end = crc_step && (bit_cnt_q == CRC_LAST_BIT);
    wire crc_restart = !locked || pass_end;
    wire [15:0] crc_next;

    clr_crc16 #(
        .POLY(CRC_POLY),
        .INIT(CRC_INIT)
    ) u_crc (
        .clk(CLK),
        .rst_n(rst_n_q),
        .restart(crc_restart),
        .step(crc_step),
        .bit_in(stream[bit_sel]),
        .crc_next(crc_next),
        .crc_q()
    );

    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            bit_cnt_q <= 7'h00;
            checksum_q <= RST_CHECKSUM;
        end else if (!locked) begin
            bit_cnt_q <= 7'h00;
            checksum_q <= RST_CHECKSUM;
        end else if (crc_step) begin
            bit_cnt_q <= bit_cnt_q + CRC_BIT_ONE;
            if (pass_end) checksum_q <= crc_next;
        end
    end

    // ----------------------------------------------------------------
    // Outputs
    // ----------------------------------------------------------------
    always_ff @(posedge CLK or negedge rst_n_q) begin
        if (!rst_n_q) begin
            RD_VALID <= 1'b0;
            RD_DATA <= 24'h000000;
            WRITE_LOCKED <= 1'b0;
            TIMER_VALUE <= RST_TIMER;
            OFFSET_TRIM <= RST_OFFSET;
            GAIN_TRIM <= RST_GAIN;
        end else begin
            RD_VALID <= rd;
            if (rd) RD_DATA <= rd_mux;
            WRITE_LOCKED <= (lock_d != UNLOCK_KEY);
            TIMER_VALUE <= we_timer ? CMD_WDATA : timer_q;
            OFFSET_TRIM <= we_offset ? CMD_WDATA : offset_q;
            GAIN_TRIM <= we_gain ? CMD_WDATA : gain_q;
        end
    end

    // ----------------------------------------------------------------
    // Checks
    // ----------------------------------------------------------------
    locked_write_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
        (locked && wr && CMD_REG_ADDR != ADDR_LOCK) |=> $stable(timer_q) && $stable(gain_q)
        && $stable(offset_q) && $stable(fixed_b_q))
        else $error("locked map accepted a write");
    key_write_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
        (wr && CMD_REG_ADDR == ADDR_LOCK) |=> (lock_q == $past(CMD_WDATA[7:0])))
        else $error("lock key write lost");
    open_write_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
        (!locked && wr && CMD_REG_ADDR == ADDR_GAIN) |=> (gain_q == $past(CMD_WDATA))
        && (GAIN_TRIM == $past(CMD_WDATA)))
        else $error("open map refused a write");
    open_sum_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
        !locked |=> (checksum_q == RST_CHECKSUM))
        else $error("checksum nonzero while unlocked");
    no_tick_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
        (locked && !MODULATOR_CLOCK_TICK) |=> $stable(bit_cnt_q))
        else $error("checksum advanced without modulator clock");
    addr_match_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
        (CMD_VALID && CMD_DEV_ADDR != DEV_ADDR) |=> !RD_VALID)
        else $error("answered a foreign device address");
    read_sum_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
        (rd && CMD_REG_ADDR == ADDR_CHECKSUM) |=> RD_VALID
        && RD_DATA == {8'h00, $past(checksum_q)})
        else $error("checksum read wrong");
    lock_flag_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
        WRITE_LOCKED == locked)
        else $error("lock flag disagrees with key");
    timer_read_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
        (rd && CMD_REG_ADDR == ADDR_TIMER) |=> (RD_DATA == $past(timer_q)))
        else $error("timer read wrong");
    timer_write_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
        (!locked && wr && CMD_REG_ADDR == ADDR_TIMER) |=> (timer_q == $past(CMD_WDATA))
        && (TIMER_VALUE == $past(CMD_WDATA)))
        else $error("timer write lost");
    offset_write_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
        (!locked && wr && CMD_REG_ADDR == ADDR_OFFSET) |=> (offset_q == $past(CMD_WDATA))
        && (OFFSET_TRIM == $past(CMD_WDATA)))
        else $error("offset write lost");
    sum_hold_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
        (locked && !MODULATOR_CLOCK_TICK) |=> $stable(checksum_q))
        else $error("checksum changed without modulator clock");
    read_answer_a: assert property (@(posedge CLK) disable iff (!rst_n_q)
        rd |=> RD_VALID)
        else $error("addressed read not answered");
endmodule : clr_lock_regs
`default_nettype wire

// file: dv/clr_host_model.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------------------------------
// Host side of the register command port
// ----------------------------------------------------------------
module clr_host_model (
    input wire logic clk,
    output logic cmd_valid,
    output logic [1:0] cmd_dev_addr,
    output logic [3:0] cmd_reg_addr,
    output logic cmd_write,
    output logic [23:0] cmd_wdata
);
    initial begin
        cmd_valid = 1'b0;
        cmd_dev_addr = 2'h0;
        cmd_reg_addr = 4'h0;
        cmd_write = 1'b0;
        cmd_wdata = 24'h000000;
    end

    // The fixed words at 0xB, 0xC and 0xE are never sent a write.
    task automatic send(input logic [1:0] da, input logic [3:0] ra, input logic wr,
                        input logic [23:0] wd);
        @(negedge clk);
        cmd_valid = 1'b1;
        cmd_dev_addr = da;
        cmd_reg_addr = ra;
        cmd_write = wr;
        cmd_wdata = wd;
    endtask : send

    // Released lines are inverted so a stale value can never pass for a live one.
    task automatic idle();
        @(negedge clk);
        cmd_valid = 1'b0;
        cmd_dev_addr = ~cmd_dev_addr;
        cmd_reg_addr = ~cmd_reg_addr;
        cmd_write = ~cmd_write;
        cmd_wdata = ~cmd_wdata;
    endtask : idle
endmodule : clr_host_model
`default_nettype wire

// file: dv/config_lock_crc_calib_regs_bench.sv
`timescale 1ns/1ps
`default_nettype none
module config_lock_crc_calib_regs_bench;
    import clr_pkg::*;
    logic clk = 1'b0;
    logic rst_b = 1'b0;
    logic tick = 1'b0;
    logic cv, cw, rv, wl;
    logic [1:0] cda;
    logic [3:0] cra;
    logic [23:0] cwd, rdd, tv, ot, gt;
    logic [23:0] mdl [8:15];
    int bad_count = 0;
    int checks = 0;

    always #2.5 clk = ~clk;

    clr_host_model host_u (.clk(clk), .cmd_valid(cv), .cmd_dev_addr(cda), .cmd_reg_addr(cra),
        .cmd_write(cw), .cmd_wdata(cwd));
    clr_lock_regs dut_u (.CLK(clk), .RST_B(rst_b), .CMD_VALID(cv), .CMD_DEV_ADDR(cda),
        .CMD_REG_ADDR(cra), .CMD_WRITE(cw), .CMD_WDATA(cwd), .MODULATOR_CLOCK_TICK(tick),
        .RD_VALID(rv), .RD_DATA(rdd), .WRITE_LOCKED(wl), .TIMER_VALUE(tv), .OFFSET_TRIM(ot),
        .GAIN_TRIM(gt));

    // ----------------------------------------------------------------
    // Shared helpers
    // ----------------------------------------------------------------
    task automatic chk(input logic [23:0] got, input logic [23:0] exp);
        checks++;
        if (got !== exp) begin
            bad_count++;
            $display("MISMATCH at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic rd(input logic [3:0] a, input logic [23:0] exp);
        host_u.send(DEV_ADDR_DEFAULT, a, 1'b0, 24'h000000);
        host_u.idle();
        chk({23'h0, rv}, 24'h000001);
        chk(rdd, exp);
    endtask : rd

    task automatic wr(input logic [3:0] a, input logic [23:0] d);
        host_u.send(DEV_ADDR_DEFAULT, a, 1'b1, d);
        host_u.idle();
    endtask : wr

    // Plain MSB-first CRC over the 128-bit configuration stream.
    function automatic logic [15:0] crc_calc(input logic [127:0] s);
        logic [15:0] c;
        logic fb;
        c = CRC_INIT;
        for (int i = 127; i >= 0; i--) begin
            fb = c[15] ^ s[i];
            c = {c[14:0], 1'b0};
            if (fb) c = c ^ CRC_POLY;
        end
        return c;
    endfunction : crc_calc

    // ----------------------------------------------------------------
    // Scenarios
    // ----------------------------------------------------------------
    task automatic t_reset();
        for (int a = 8; a <= 15; a++) rd(a[3:0], mdl[a]);
        chk({23'h0, wl}, 24'h000000);
        chk(gt, 24'h800000);
    endtask : t_reset

    task automatic t_rw();
        host_u.send(DEV_ADDR_DEFAULT, 4'h8, 1'b1, 24'hABCDEF);
        host_u.send(DEV_ADDR_DEFAULT, 4'h9, 1'b1, 24'hFFFFFE);
        host_u.send(DEV_ADDR_DEFAULT, 4'hA, 1'b1, 24'h7FFFFF);
        host_u.send(DEV_ADDR_DEFAULT, 4'hF, 1'b1, 24'h001234);
        host_u.idle();
        host_u.idle();
        mdl[8] = 24'hABCDEF;
        mdl[9] = 24'hFFFFFE;
        mdl[10] = 24'h7FFFFF;
        chk(tv, mdl[8]);
        chk(ot, mdl[9]);
        chk(gt, mdl[10]);
        for (int a = 8; a <= 15; a++) rd(a[3:0], mdl[a]);
    endtask : t_rw

    task automatic t_refuse();
        host_u.send(2'h2, 4'h8, 1'b0, 24'h000000);
        host_u.idle();
        chk({23'h0, rv}, 24'h000000);
        host_u.send(DEV_ADDR_DEFAULT, 4'h3, 1'b0, 24'h000000);
        host_u.idle();
        chk({23'h0, rv}, 24'h000000);
        host_u.send(2'h0, 4'h8, 1'b1, 24'h111111);
        host_u.idle();
        rd(4'h8, mdl[8]);
    endtask : t_refuse

    task automatic t_lock();
        tick = 1'b1;
        repeat (40) @(negedge clk);
        tick = 1'b0;
        wr(4'hD, 24'h000012);
        chk({23'h0, wl}, 24'h000001);
        wr(4'h8, 24'h555555);
        wr(4'hD, 24'h00003C);
        mdl[13] = 24'h00003C;
        rd(4'h8, mdl[8]);
        rd(4'hD, mdl[13]);
        repeat (20) @(negedge clk);
        rd(4'hF, 24'h000000);
    endtask : t_lock

    task automatic t_crc();
        logic [15:0] e;
        e = crc_calc({mdl[8], mdl[9], mdl[10], mdl[11], mdl[12][7:0], mdl[13][7:0],
            mdl[14][15:0]});
        tick = 1'b1;
        repeat (128) @(negedge clk);
        tick = 1'b0;
        rd(4'hF, {8'h00, e});
        wr(4'hD, 24'h0000A5);
        chk({23'h0, wl}, 24'h000000);
        rd(4'hF, 24'h000000);
        wr(4'h8, 24'h000001);
        rd(4'h8, 24'h000001);
    endtask : t_crc

    // A reset in mid-run must bring a locked, rewritten map back to its reset image.
    task automatic t_rerst();
        wr(4'hD, 24'h00005A);
        chk({23'h0, wl}, 24'h000001);
        rst_b = 1'b0;
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        mdl[8] = RST_TIMER;
        mdl[9] = RST_OFFSET;
        mdl[10] = RST_GAIN;
        mdl[13] = {16'h0, RST_LOCK};
        t_reset();
    endtask : t_rerst

    // ----------------------------------------------------------------
    // Sequence, watchdog and verdict
    // ----------------------------------------------------------------
    task automatic finish_test();
        $display("checks=%0d bad_count=%0d", checks, bad_count);
        if (bad_count == 0 && checks > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask : finish_test

    initial begin
        mdl = '{RST_TIMER, RST_OFFSET, RST_GAIN, RST_FIXED_B, {16'h0, RST_FIXED_C},
            {16'h0, RST_LOCK}, {8'h0, RST_FIXED_E}, {8'h0, RST_CHECKSUM}};
        repeat (4) @(negedge clk);
        rst_b = 1'b1;
        repeat (3) @(negedge clk);
        t_reset();
        t_rw();
        t_refuse();
        t_lock();
        t_crc();
        t_rerst();
        finish_test();
    end

    // The whole sequence needs well under 1000 cycles.
    initial begin
        #20000;
        bad_count++;
        finish_test();
    end
endmodule : config_lock_crc_calib_regs_bench
`default_nettype wire

// file: include/clr_pkg.sv
`default_nettype none
package clr_pkg;
    // ----------------------------------------------------------------
    // Register map
    // ----------------------------------------------------------------
    localparam logic [3:0] ADDR_TIMER = 4'h8;
    localparam logic [3:0] ADDR_OFFSET = 4'h9;
    localparam logic [3:0] ADDR_GAIN = 4'hA;
    localparam logic [3:0] ADDR_FIXED_B = 4'hB;
    localparam logic [3:0] ADDR_FIXED_C = 4'hC;
    localparam logic [3:0] ADDR_LOCK = 4'hD;
    localparam logic [3:0] ADDR_FIXED_E = 4'hE;
    localparam logic [3:0] ADDR_CHECKSUM = 4'hF;
    // Only the upper half of the map lives here.
    localparam logic ADDR_UPPER_BIT = 1'h1;

    // ----------------------------------------------------------------
    // Widths and reset values
    // ----------------------------------------------------------------
    localparam int WORD_W = 24;
    localparam int BYTE_W = 8;
    localparam int HALF_W = 16;
    localparam logic [23:0] RST_TIMER = 24'h000000;
    localparam logic [23:0] RST_OFFSET = 24'h000000;
    localparam logic [23:0] RST_GAIN = 24'h800000;
    localparam logic [23:0] RST_FIXED_B = 24'h900000;
    localparam logic [7:0] RST_FIXED_C = 8'h30;
    localparam logic [7:0] RST_LOCK = 8'hA5;
    localparam logic [15:0] RST_FIXED_E = 16'h000E;
    localparam logic [15:0] RST_CHECKSUM = 16'h0000;
    localparam logic [7:0] UNLOCK_KEY = 8'hA5;
    localparam logic [1:0] DEV_ADDR_DEFAULT = 2'h1;

    // ----------------------------------------------------------------
    // Checksum
    // ----------------------------------------------------------------
    localparam logic [15:0] CRC_POLY = 16'h1021;
    localparam logic [15:0] CRC_INIT = 16'hFFFF;
    // 4 x 24 + 8 + 8 + 16 bits of writable configuration.
    localparam int CRC_STREAM_W = 128;
    localparam logic [6:0] CRC_LAST_BIT = 7'h7F;
    localparam logic [6:0] CRC_BIT_ONE = 7'h01;
endpackage : clr_pkg
`default_nettype wire
